/* include/timer16_defs.vh */
// register map, field positions and reset values of the 16-bit timer block
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// apb byte offsets
`define OFS_MODE_CTRL 12'h000
`define OFS_PRESC_MODE 12'h004
`define OFS_OUT_CTRL 12'h008
`define OFS_PRIMARY_CMP 12'h00c
`define OFS_SECONDARY_CMP 12'h010
`define OFS_COUNT_VALUE 12'h014

// timer_mode_control fields
`define MODE_HI 3
`define MODE_LO 2
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_CLR_EDGE 2'h2
`define MODE_CLR_MATCH 2'h3

// prescaler_mode fields
`define CLK_SEL_HI 1
`define CLK_SEL_LO 0
`define EDGE_SEL_HI 5
`define EDGE_SEL_LO 4
`define CLK_SEL_FULL 2'h0
`define CLK_SEL_DIV4 2'h1
`define CLK_SEL_DIV256 2'h2
`define CLK_SEL_EVENT 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

// timer_output_control fields
`define OUT_ENABLE_BIT 0
`define INV_PRIMARY_BIT 1
`define LEVEL_CLEAR_BIT 2
`define LEVEL_SET_BIT 3
`define INV_SECONDARY_BIT 4

// reset values
`define RST_MODE_CTRL 2'h0
`define RST_PRESC_MODE 2'h0
`define RST_EDGE_SEL 2'h0
`define RST_OUT_CTRL 8'h00
`define RST_COMPARE 16'h0000
`define RST_COUNT 16'h0000

// prescaler terminal values for the divided count clocks
`define DIV4_TERMINAL 8'h03
`define DIV256_TERMINAL 8'hff

`endif

/* rtl/timer16_edge_filter.v */
// two-flop synchroniser and two-sample glitch filter for the event input pin
`timescale 1ns/10ps
module timer16_edge_filter (
	input wire i_clk,
	input wire i_rst,
	input wire i_pin,
	output reg o_rise,
	output reg o_fall
);
	reg meta_q;
	reg sync_q;
	reg prev_q;
	reg level_q;

	// level accepted only after two equal samples, so one-cycle spikes vanish
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			level_q <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
			if (sync_q == prev_q && sync_q != level_q) begin
				level_q <= sync_q;
				o_rise <= sync_q;
				o_fall <= ~sync_q;
			end
		end
	end
endmodule // timer16_edge_filter

/* rtl/timer16_top.v */
// 16-bit interval / square-wave / event counter timer with apb registers
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_top #(
	parameter CNT_W = 16,
	parameter ADDR_W = 12
) (
	input wire I_MCLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output reg O_PREADY,
	output reg O_PSLVERR,
	input wire I_EVENT_IN_PIN,
	output reg O_TIMER_OUT_PIN,
	output reg O_PRIMARY_MATCH_IRQ,
	output reg O_SECONDARY_MATCH_IRQ
);
	// software registers
	reg [1:0] op_mode_q;
	reg [1:0] clk_sel_q;
	reg [1:0] edge_sel_q;
	reg out_enable_q;
	reg inv_primary_q;
	reg inv_secondary_q;
	reg [CNT_W-1:0] primary_compare_q;
	reg [CNT_W-1:0] secondary_compare_q;

	// timer state
	reg [CNT_W-1:0] count_value_q;
	reg [CNT_W-1:0] count_value_d;
	reg [7:0] presc_q;
	reg started_q;
	reg out_level_q;
	reg out_level_d;
	reg primary_hit;
	reg secondary_hit;
	reg tick;

	// bus decode
	reg [31:0] rdata_d;
	reg mapped_d;
	wire setup_phase;
	wire access_done;
	wire wr_en;
	wire wr_mode;
	wire wr_presc;
	wire wr_out;
	wire wr_pcmp;
	wire wr_scmp;

	// filtered event edges
	wire ev_rise;
	wire ev_fall;
	reg ev_edge;
	wire running;

	timer16_edge_filter timer16_edge_filter_i (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_pin(I_EVENT_IN_PIN),
		.o_rise(ev_rise),
		.o_fall(ev_fall)
	);

	// valid edge of the event pin, as picked by the edge select field
	always @* begin
		case (edge_sel_q)
			`EDGE_FALL: ev_edge = ev_fall;
			`EDGE_RISE: ev_edge = ev_rise;
			`EDGE_BOTH: ev_edge = ev_rise | ev_fall;
			default: ev_edge = 1'b0;
		endcase
	end

	assign running = (op_mode_q != `MODE_STOP);

	// apb: answer is registered, so every access takes exactly one wait-free access cycle
	assign setup_phase = I_PSEL & ~I_PENABLE;
	assign access_done = I_PSEL & I_PENABLE & O_PREADY;
	assign wr_en = access_done & I_PWRITE & ~O_PSLVERR;
	assign wr_mode = wr_en && (I_PADDR == `OFS_MODE_CTRL);
	assign wr_presc = wr_en && (I_PADDR == `OFS_PRESC_MODE);
	assign wr_out = wr_en && (I_PADDR == `OFS_OUT_CTRL);
	assign wr_pcmp = wr_en && (I_PADDR == `OFS_PRIMARY_CMP);
	assign wr_scmp = wr_en && (I_PADDR == `OFS_SECONDARY_CMP);

	always @* begin
		rdata_d = 32'h00000000;
		mapped_d = 1'b1;
		if (I_PADDR == `OFS_MODE_CTRL) begin
			rdata_d[`MODE_HI:`MODE_LO] = op_mode_q;
		end else if (I_PADDR == `OFS_PRESC_MODE) begin
			rdata_d[`CLK_SEL_HI:`CLK_SEL_LO] = clk_sel_q;
			rdata_d[`EDGE_SEL_HI:`EDGE_SEL_LO] = edge_sel_q;
		end else if (I_PADDR == `OFS_OUT_CTRL) begin
			// level set / clear are triggers and always read back as zero
			rdata_d[`OUT_ENABLE_BIT] = out_enable_q;
			rdata_d[`INV_PRIMARY_BIT] = inv_primary_q;
			rdata_d[`INV_SECONDARY_BIT] = inv_secondary_q;
		end else if (I_PADDR == `OFS_PRIMARY_CMP) begin
			rdata_d[CNT_W-1:0] = primary_compare_q;
		end else if (I_PADDR == `OFS_SECONDARY_CMP) begin
			rdata_d[CNT_W-1:0] = secondary_compare_q;
		end else if (I_PADDR == `OFS_COUNT_VALUE) begin
			rdata_d[CNT_W-1:0] = count_value_q;
		end else begin
			mapped_d = 1'b0;
		end
	end

	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_PRDATA <= 32'h00000000;
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= setup_phase;
			if (setup_phase) begin
				O_PRDATA <= rdata_d;
				O_PSLVERR <= ~mapped_d;
			end else if (access_done) begin
				O_PRDATA <= 32'h00000000;
				O_PSLVERR <= 1'b0;
			end
		end
	end

	// register writes
	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			op_mode_q <= `RST_MODE_CTRL;
			clk_sel_q <= `RST_PRESC_MODE;
			edge_sel_q <= `RST_EDGE_SEL;
			out_enable_q <= 1'b0;
			inv_primary_q <= 1'b0;
			inv_secondary_q <= 1'b0;
			primary_compare_q <= `RST_COMPARE;
			secondary_compare_q <= `RST_COMPARE;
		end else begin
			if (wr_mode) begin
				op_mode_q <= I_PWDATA[`MODE_HI:`MODE_LO];
			end
			if (wr_presc) begin
				clk_sel_q <= I_PWDATA[`CLK_SEL_HI:`CLK_SEL_LO];
				edge_sel_q <= I_PWDATA[`EDGE_SEL_HI:`EDGE_SEL_LO];
			end
			if (wr_out) begin
				out_enable_q <= I_PWDATA[`OUT_ENABLE_BIT];
				inv_primary_q <= I_PWDATA[`INV_PRIMARY_BIT];
				inv_secondary_q <= I_PWDATA[`INV_SECONDARY_BIT];
			end
			// zero is not guarded; in clear-on-match mode a zero compare simply fires every count clock after the arming one
			if (wr_pcmp) begin
				primary_compare_q <= I_PWDATA[CNT_W-1:0];
			end
			if (wr_scmp) begin
				secondary_compare_q <= I_PWDATA[CNT_W-1:0];
			end
		end
	end

	// count clock: prescaler runs only while the timer runs, so phase restarts with it
	always @* begin
		case (clk_sel_q)
			`CLK_SEL_FULL: tick = running;
			`CLK_SEL_DIV4: tick = running && ({6'h00, presc_q[1:0]} == `DIV4_TERMINAL);
			`CLK_SEL_DIV256: tick = running && (presc_q == `DIV256_TERMINAL);
			default: tick = running && ev_edge;
		endcase
	end

	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			presc_q <= 8'h00;
		end else if (!running) begin
			presc_q <= 8'h00;
		end else begin
			presc_q <= presc_q + 8'h01;
		end
	end

	// counter next value and match events
	always @* begin
		count_value_d = count_value_q;
		primary_hit = 1'b0;
		secondary_hit = 1'b0;
		if (!running) begin
			count_value_d = `RST_COUNT;
		end else if (op_mode_q == `MODE_CLR_EDGE && ev_edge && clk_sel_q != `CLK_SEL_EVENT) begin
			// event pin cannot be both clock and clear source
			count_value_d = `RST_COUNT;
		end else if (tick && started_q) begin
			primary_hit = (count_value_q == primary_compare_q);
			secondary_hit = (count_value_q == secondary_compare_q);
			if (primary_hit && op_mode_q == `MODE_CLR_MATCH) begin
				count_value_d = `RST_COUNT;
			end else begin
				count_value_d = count_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// first edge after start only arms the counter, giving compare plus two
	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			started_q <= 1'b0;
		end else if (!running) begin
			started_q <= 1'b0;
		end else if (tick) begin
			started_q <= 1'b1;
		end
	end

	// in the divided and full-rate clocks the arming edge is the first count clock
	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			count_value_q <= `RST_COUNT;
		end else begin
			count_value_q <= count_value_d;
		end
	end

	// output level: trigger bits set it, matches invert it, disable forces low
	always @* begin
		out_level_d = out_level_q;
		if (!out_enable_q) begin
			out_level_d = 1'b0;
		end else begin
			if (wr_out && I_PWDATA[`LEVEL_SET_BIT] && !I_PWDATA[`LEVEL_CLEAR_BIT]) begin
				out_level_d = 1'b1;
			end else if (wr_out && I_PWDATA[`LEVEL_CLEAR_BIT] && !I_PWDATA[`LEVEL_SET_BIT]) begin
				out_level_d = 1'b0;
			end
			if ((primary_hit && inv_primary_q) ^ (secondary_hit && inv_secondary_q)) begin
				out_level_d = ~out_level_d;
			end
		end
	end

	always @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			out_level_q <= 1'b0;
			O_TIMER_OUT_PIN <= 1'b0;
			O_PRIMARY_MATCH_IRQ <= 1'b0;
			O_SECONDARY_MATCH_IRQ <= 1'b0;
		end else begin
			out_level_q <= out_level_d;
			O_TIMER_OUT_PIN <= out_level_d;
			O_PRIMARY_MATCH_IRQ <= primary_hit;
			O_SECONDARY_MATCH_IRQ <= secondary_hit;
		end
	end
endmodule // timer16_top

/* tb/timer16_top_sva.sv */
// port-level checker for the timer block
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_top_sva #(
	parameter CNT_W = 16,
	parameter ADDR_W = 12
) (
	input wire I_MCLK,
	input wire I_SYS_RST,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire I_EVENT_IN_PIN,
	input wire O_TIMER_OUT_PIN,
	input wire O_PRIMARY_MATCH_IRQ,
	input wire O_SECONDARY_MATCH_IRQ
);
	// output control writes may move the pin without a match
	wire wr_oc = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `OFS_OUT_CTRL);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);
	setup_ready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
		else $error("no ready after setup");
	ready_cause_a: assert property (O_PREADY |-> $past(I_PSEL && !I_PENABLE))
		else $error("ready without setup");
	unmapped_err_a: assert property (I_PSEL && !I_PENABLE && I_PADDR > 12'h014 |=> O_PSLVERR)
		else $error("no error on unmapped address");
	err_data_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
		else $error("error without ready or with data");
	idle_data_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
		else $error("read data outside access");
	upper_zero_a: assert property (O_PREADY |-> O_PRDATA[31:16] == 16'h0)
		else $error("upper read bits set");
	irq_pulse_a: assert property (O_PRIMARY_MATCH_IRQ |=> !O_PRIMARY_MATCH_IRQ)
		else $error("primary irq longer than one cycle");
	pin_cause_a: assert property (!$stable(O_TIMER_OUT_PIN) |-> O_PRIMARY_MATCH_IRQ
		|| O_SECONDARY_MATCH_IRQ || $past(wr_oc) || $past(wr_oc, 2))
		else $error("pin moved without cause");
	cover property (O_PRIMARY_MATCH_IRQ && O_TIMER_OUT_PIN);
	cover property (O_SECONDARY_MATCH_IRQ);
	cover property (O_PSLVERR);
endmodule // timer16_top_sva

bind timer16_top timer16_top_sva #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) timer16_top_sva_i (
	.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EVENT_IN_PIN(I_EVENT_IN_PIN),
	.O_TIMER_OUT_PIN(O_TIMER_OUT_PIN), .O_PRIMARY_MATCH_IRQ(O_PRIMARY_MATCH_IRQ),
	.O_SECONDARY_MATCH_IRQ(O_SECONDARY_MATCH_IRQ));

/* tb/timer16_event_src.sv */
// event pin source standing in for the outside world
`timescale 1ns/10ps
module timer16_event_src (
	input wire i_clk,
	output reg o_pin
);
	integer k;
	initial o_pin = 1'b0;
	// high held four clocks, low at least four, well above two clock periods
	task pulses(input integer n);
		for (k = 0; k < n; k = k + 1) begin
			@(posedge i_clk) o_pin <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_pin <= 1'b0;
			repeat (4) @(posedge i_clk);
		end
	endtask
	// one-clock spike, too short to pass the filter
	task spike;
		@(posedge i_clk) o_pin <= 1'b1;
		@(posedge i_clk) o_pin <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
endmodule // timer16_event_src

/* tb/timer16_top_tb_top.sv */
// self-checking bench for the timer block
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_top_tb_top;
	reg clk, rst, psel, pen, pwr, er, tprev;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, evt, tout, pirq, sirq;
	integer bad_count, cmp_count, cyc, last, gap, tlast, tgap, irqs, secs, togs, i, j;
	timer16_top timer16_top_i (.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVENT_IN_PIN(evt),
		.O_TIMER_OUT_PIN(tout), .O_PRIMARY_MATCH_IRQ(pirq), .O_SECONDARY_MATCH_IRQ(sirq));
	timer16_event_src timer16_event_src_i (.i_clk(clk), .o_pin(evt));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// interrupt and toggle spacing, measured in clocks
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tprev <= tout;
		if (pirq === 1'b1) begin
			irqs <= irqs + 1;
			gap <= cyc - last;
			last <= cyc;
		end
		if (sirq === 1'b1)
			secs <= secs + 1;
		if (tout !== tprev) begin
			togs <= togs + 1;
			tgap <= cyc - tlast;
			tlast <= cyc;
		end
	end
	task end_of_test;
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task fail(input string what);
		bad_count = bad_count + 1;
		$display("CHECK FAILED at %0t: %0s", $time, what);
	endtask
	task chk(input [31:0] got, input [31:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (got !== exp)
			fail($sformatf("%0s got %h exp %h", what, got, exp));
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		integer n;
		@(posedge clk);
		{psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 16; n = n + 1) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				{rd, er} = {prdata, pslverr};
				n = 99;
			end
		end
		if (n != 100) begin
			fail("bus timeout");
			end_of_test;
		end
		{psel, pen} <= 2'b00;
	endtask
	task wait_irq(input integer n);
		integer t, k;
		t = irqs + n;
		for (k = 0; k < 3000 && irqs < t; k = k + 1)
			@(posedge clk);
		if (irqs < t) begin
			fail("irq timeout");
			end_of_test;
		end
	endtask
	// n pulses on the event pin, then time for filter and counter
	task edges(input integer n);
		timer16_event_src_i.pulses(n);
		repeat (12) @(posedge clk);
	endtask
	initial begin
		{psel, pen, pwr, paddr, pwdata, rd, er, tprev} = 0;
		{bad_count, cmp_count, cyc, last, gap, tlast, tgap, irqs, secs, togs} = 0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 6; i = i + 1) begin
			apb(12'(4 * i), 1'b0, 32'h0);
			chk(rd, 32'h0, "reset value");
		end
		apb(`OFS_PRIMARY_CMP, 1'b1, 32'hffffffff);
		apb(`OFS_PRIMARY_CMP, 1'b0, 32'h0);
		chk(rd, 32'h0000ffff, "compare readback");
		apb(`OFS_COUNT_VALUE, 1'b1, 32'h5);
		repeat (10) @(posedge clk);
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd, 32'h0, "stopped count");
		apb(12'h018, 1'b0, 32'h0);
		chk({rd[30:0], er}, 32'h1, "unmapped");
		apb(`OFS_PRIMARY_CMP, 1'b1, 32'h3);
		apb(`OFS_SECONDARY_CMP, 1'b1, 32'h2);
		apb(`OFS_MODE_CTRL, 1'b1, 32'hc);
		wait_irq(3);
		chk(gap, 4, "interval");
		chk(secs >= 2, 1, "secondary irq");
		chk(togs, 0, "pin disabled");
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd < 4, 1, "count cleared");
		apb(`OFS_OUT_CTRL, 1'b1, 32'h3);
		wait_irq(1);
		j = togs;
		wait_irq(2);
		chk(togs - j, 2, "toggle per match");
		chk(tgap, 4, "half period");
		apb(`OFS_OUT_CTRL, 1'b1, 32'h1);
		// a match in the write cycle still inverts; let it be counted first
		repeat (2) @(posedge clk);
		j = togs;
		wait_irq(2);
		chk(togs - j, 0, "no inversion");
		apb(`OFS_OUT_CTRL, 1'b1, 32'h9);
		repeat (2) @(posedge clk);
		chk(tout, 1, "level set");
		apb(`OFS_OUT_CTRL, 1'b1, 32'h5);
		repeat (2) @(posedge clk);
		chk(tout, 0, "level clear");
		apb(`OFS_OUT_CTRL, 1'b1, 32'h9);
		apb(`OFS_OUT_CTRL, 1'b1, 32'h0);
		repeat (3) @(posedge clk);
		chk(tout, 0, "pin low");
		apb(`OFS_MODE_CTRL, 1'b1, 32'h0);
		// divided clocks need a stopped timer while reprogrammed
		for (i = 1; i < 3; i = i + 1) begin
			apb(`OFS_PRESC_MODE, 1'b1, i);
			apb(`OFS_PRIMARY_CMP, 1'b1, 32'h1);
			apb(`OFS_MODE_CTRL, 1'b1, 32'hc);
			wait_irq(3);
			chk(gap, (i == 1) ? 8 : 512, "divided period");
			apb(`OFS_MODE_CTRL, 1'b1, 32'h0);
		end
		apb(`OFS_PRESC_MODE, 1'b1, 32'h13);
		apb(`OFS_PRIMARY_CMP, 1'b1, 32'h2);
		apb(`OFS_MODE_CTRL, 1'b1, 32'hc);
		j = irqs;
		edges(3);
		chk(irqs - j, 0, "early first irq");
		edges(1);
		chk(irqs - j, 1, "first irq");
		edges(2);
		chk(irqs - j, 1, "early later irq");
		edges(1);
		chk(irqs - j, 2, "later irq");
		edges(1);
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd, 32'h1, "event count");
		timer16_event_src_i.spike;
		repeat (12) @(posedge clk);
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd, 32'h1, "spike counted");
		// free run: a match interrupts but does not clear
		apb(`OFS_MODE_CTRL, 1'b1, 32'h0);
		apb(`OFS_PRESC_MODE, 1'b1, 32'h30);
		apb(`OFS_MODE_CTRL, 1'b1, 32'h4);
		wait_irq(1);
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd > 3, 1, "free run no clear");
		// clear on pin edge: count restarts near the pulse, not from mode start
		apb(`OFS_MODE_CTRL, 1'b1, 32'h8);
		repeat (100) @(posedge clk);
		edges(1);
		apb(`OFS_COUNT_VALUE, 1'b0, 32'h0);
		chk(rd < 20, 1, "edge clear");
		end_of_test;
	end
endmodule // timer16_top_tb_top
